// ---- pwc_pkg.sv ----
// shared constants, symbol classifier and register defaults of the pulse coded port
package pwc_pkg;
   // ----------------------------------------
   // timing
   // ----------------------------------------
   localparam int CLK_HZ = 50000000;
   localparam int RATE_MIN_BPS = 1000;
   localparam int RATE_MAX_BPS = 10000;
   localparam int TX_RATE_BPS = 7000;
   localparam int HOST_RATE_BPS = 5000;
   localparam int TURN_GAP_US = 10;
   localparam int TURN_GAP_CYC = (TURN_GAP_US * CLK_HZ + 999999) / 1000000;
   localparam int TX_BIT_CYC = CLK_HZ / TX_RATE_BPS;
   localparam int HOST_BIT_CYC = CLK_HZ / HOST_RATE_BPS;
   localparam int SYM_MIN_CYC = CLK_HZ / RATE_MAX_BPS / 2;
   localparam int RX_TIMEOUT_CYC = 2 * (CLK_HZ / RATE_MIN_BPS);
   localparam int REPLY_SYMS = 66;
   localparam int REPLY_WAIT_CYC = 2 * (REPLY_SYMS * TX_BIT_CYC + TURN_GAP_CYC + TX_BIT_CYC);
   // shortest accepted period as a fraction of the receive timeout or of the bit time
   localparam int DEV_MIN_DIV = RX_TIMEOUT_CYC / SYM_MIN_CYC;
   localparam int HOST_MIN_DIV = HOST_BIT_CYC / SYM_MIN_CYC;
   localparam int CNT_W = 20;
   // ----------------------------------------
   // symbols and frames
   // ----------------------------------------
   localparam logic [1:0] SYM_ZERO = 2'h0;
   localparam logic [1:0] SYM_ONE = 2'h1;
   localparam logic [1:0] SYM_IDLE = 2'h2;
   localparam logic [1:0] SYM_BAD = 2'h3;
   localparam logic [3:0] MAX_BYTES = 4'h8;
   localparam logic [6:0] TX_SYMS_ONE = 7'h0a;
   localparam logic [6:0] TX_SYMS_BLOCK = 7'h42;
   // ----------------------------------------
   // device register map
   // ----------------------------------------
   localparam logic [6:0] LUT_LAST = 7'h5d;
   localparam logic [6:0] INIT_FIRST = 7'h66;
   localparam logic [6:0] FNL_LAST = 7'h78;
   localparam logic [6:0] STATUS_ADDR = 7'h7e;
   localparam logic [6:0] BURN_ADDR = 7'h7f;
   localparam logic [7:0] BURN_LOW = 8'h08;
   localparam logic [7:0] BURN_FNL = 8'h10;
   localparam logic [7:0] BURN_ALL = 8'h20;
   localparam logic [7:0] BURN_RO = 8'h40;
   localparam logic [7:0] BURN_OFF = 8'h80;
   localparam logic [7:0] STATUS_BASE = 8'h20;
   localparam logic [7:0] ST_LOW_DONE = 8'h01;
   localparam logic [7:0] ST_FNL_DONE = 8'h02;
   localparam logic [7:0] ST_RO = 8'h04;
   localparam logic [7:0] ST_OFF = 8'h08;
   localparam logic [7:0] NV_MASK = 8'h0f;
   localparam int ST_RO_POS = 2;
   localparam int ST_OFF_POS = 3;
   localparam logic [7:0] DEF_LUT_EVEN = 8'h40;
   localparam logic [7:0] DEF_OSC0 = 8'h0e;
   localparam logic [7:0] DEF_OSC1 = 8'h14;
   localparam logic [7:0] DEF_OSC2 = 8'h45;
   localparam logic [7:0] DEF_OSC3 = 8'h1b;
   localparam logic [7:0] DEF_OUT = 8'ha2;
   // ----------------------------------------
   // host command registers
   // ----------------------------------------
   localparam logic [3:0] HREG_CTRL = 4'h0;
   localparam logic [3:0] HREG_TARGET = 4'h1;
   localparam logic [3:0] HREG_COUNT = 4'h2;
   localparam logic [3:0] HREG_STAT = 4'h3;
   localparam logic [3:0] HREG_BUF = 4'h8;

   // high time against period: quarter, half, three quarter bands
   function automatic logic [1:0] classify(input logic [CNT_W-1:0] high,
                                           input logic [CNT_W-1:0] per,
                                           input logic [CNT_W-1:0] min_per);
      logic [CNT_W+2:0] h8;
      logic [CNT_W+2:0] p;
      h8 = {high, 3'h0};
      p = {3'h0, per};
      if (per < min_per || h8 < p || h8 > (p << 3) - p) begin
         return SYM_BAD;
      end else if (h8 < p + (p << 1)) begin
         return SYM_ZERO;
      end else if (h8 < p + (p << 2)) begin
         return SYM_IDLE;
      end
      return SYM_ONE;
   endfunction : classify

   function automatic logic [7:0] reg_default(input logic [6:0] a);
      case (a)
         7'h6e: return DEF_OSC0;
         7'h6f: return DEF_OSC1;
         7'h70: return DEF_OSC2;
         7'h71, 7'h77: return DEF_OSC3;
         7'h72, 7'h78: return DEF_OUT;
         default: return (a <= LUT_LAST && !a[0]) ? DEF_LUT_EVEN : 8'h00;
      endcase
   endfunction : reg_default
endpackage : pwc_pkg

// ---- pulse_coded_port.sv ----
// link between master and device: supply pulses one way, current pulses back
`timescale 1ns/1ps
interface pulse_coded_port;
   logic supply_symbol_input;
   logic indicator_sink;
   modport dev(input supply_symbol_input, output indicator_sink);
   modport host(output supply_symbol_input, input indicator_sink);
endinterface : pulse_coded_port

// ---- pwc_device.sv ----
// device end of the pulse coded configuration port with burn and lock logic
//
// Our own choice: strobed register access.
`timescale 1ns/1ps
module pwc_device #(
   parameter int TX_BIT_CYC = pwc_pkg::TX_BIT_CYC,
   parameter int RX_TIMEOUT_CYC = pwc_pkg::RX_TIMEOUT_CYC
) (
   // clock and reset
   input wire logic CLK,
   input wire logic RESETN,
   // link to the master
   pulse_coded_port.dev LINK,
   // nonvolatile burn store
   input wire logic [7:0] NV_STATUS,
   output logic BURN_STROBE,
   output logic [7:0] BURN_CODE,
   // core readback and activity
   input wire logic [6:0] CFG_ADDR,
   output logic [7:0] CFG_DATA,
   output logic TX_ACTIVE
);
   localparam int W = pwc_pkg::CNT_W;

   typedef enum logic [4:0] {
      ST_HUNT = 5'h01,
      ST_CMD = 5'h02,
      ST_WDATA = 5'h04,
      ST_TURN = 5'h08,
      ST_TX = 5'h10
   } dev_state_type;

   dev_state_type state_r, state_nxt;
   logic in_s1_r, in_s2_r, in_d_r;
   logic [W-1:0] cnt_r, high_r, tx_cnt_r;
   logic have_prev_r;
   logic [7:0] shift_r, status_r, burn_code_r, cfg_r;
   logic [2:0] bitcnt_r;
   logic [3:0] bytes_r;
   logic [6:0] addr_r, tx_idx_r;
   logic ro_r, off_r, nv_done_r, sink_r, burn_r, tx_act_r;
   logic [7:0] mem_r [0:127];

   // ----------------------------------------
   // receive decode
   // ----------------------------------------
   wire rise = in_s2_r & ~in_d_r;
   wire fall = ~in_s2_r & in_d_r;
   wire listening = (state_r != ST_TURN) && (state_r != ST_TX) && !off_r;
   wire timeout = cnt_r == W'(RX_TIMEOUT_CYC - 1);
   wire [1:0] sym = pwc_pkg::classify(high_r, cnt_r,
      W'(RX_TIMEOUT_CYC / pwc_pkg::DEV_MIN_DIV));
   wire sym_evt = rise & have_prev_r & listening;
   wire is_bit = sym_evt && (sym == pwc_pkg::SYM_ZERO || sym == pwc_pkg::SYM_ONE);
   wire is_idle = sym_evt && (sym == pwc_pkg::SYM_IDLE);
   wire is_bad = sym_evt && (sym == pwc_pkg::SYM_BAD);
   wire [7:0] byte_in = {shift_r[6:0], sym == pwc_pkg::SYM_ONE};
   wire byte_done = is_bit && (bitcnt_r == 3'h7);
   wire cmd_done = byte_done && (state_r == ST_CMD);
   wire wr_en = byte_done && (state_r == ST_WDATA) && (bytes_r < pwc_pkg::MAX_BYTES) && !ro_r;
   wire writable = (addr_r <= pwc_pkg::LUT_LAST)
      || (addr_r >= pwc_pkg::INIT_FIRST && addr_r <= pwc_pkg::FNL_LAST);
   wire mem_we = wr_en & writable;
   wire burn_hit = wr_en && (addr_r == pwc_pkg::BURN_ADDR);
   wire [7:0] burn_mask =
      (byte_in == pwc_pkg::BURN_LOW) ? pwc_pkg::ST_LOW_DONE :
      (byte_in == pwc_pkg::BURN_FNL) ? pwc_pkg::ST_FNL_DONE :
      (byte_in == pwc_pkg::BURN_ALL) ? (pwc_pkg::ST_LOW_DONE | pwc_pkg::ST_FNL_DONE) :
      (byte_in == pwc_pkg::BURN_RO) ? pwc_pkg::ST_RO :
      (byte_in == pwc_pkg::BURN_OFF) ? pwc_pkg::ST_OFF : 8'h00;
   wire burn_ok = burn_hit && (burn_mask != 8'h00);

   // ----------------------------------------
   // transmit decode
   // ----------------------------------------
   wire [6:0] tx_total = (addr_r == pwc_pkg::STATUS_ADDR) ? pwc_pkg::TX_SYMS_ONE
      : pwc_pkg::TX_SYMS_BLOCK;
   wire [6:0] tx_k = tx_idx_r - 7'h01;
   wire [6:0] rd_addr = addr_r + {4'h0, tx_k[5:3]};
   wire [7:0] rd_byte = (rd_addr == pwc_pkg::STATUS_ADDR) ? status_r : mem_r[rd_addr];
   wire tx_bit = rd_byte[3'h7 - tx_k[2:0]];
   wire tx_idle = (tx_idx_r == 7'h00) || (tx_idx_r == tx_total - 7'h01);
   wire [W-1:0] tx_high = tx_idle ? W'(TX_BIT_CYC / 2)
      : tx_bit ? W'((3 * TX_BIT_CYC) / 4) : W'(TX_BIT_CYC / 4);
   wire tx_sym_end = tx_cnt_r == W'(TX_BIT_CYC - 1);
   wire tx_last = tx_sym_end && (tx_idx_r == tx_total - 7'h01);
   wire turn_end = tx_cnt_r == W'(pwc_pkg::TURN_GAP_CYC + TX_BIT_CYC - 1);
   wire [7:0] cfg_byte = (CFG_ADDR == pwc_pkg::STATUS_ADDR) ? status_r : mem_r[CFG_ADDR];

   // ----------------------------------------
   // frame sequencing
   // ----------------------------------------
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         ST_HUNT: begin
            if (is_idle) begin
               state_nxt = ST_CMD;
            end
         end
         ST_CMD: begin
            if (is_bad || timeout) begin
               state_nxt = ST_HUNT;
            end else if (cmd_done) begin
               state_nxt = byte_in[7] ? ST_TURN : ST_WDATA;
            end
         end
         ST_WDATA: begin
            if (is_bad || is_idle || timeout) begin
               state_nxt = ST_HUNT;
            end
         end
         ST_TURN: begin
            if (turn_end) begin
               state_nxt = ST_TX;
            end
         end
         ST_TX: begin
            if (tx_last) begin
               state_nxt = ST_HUNT;
            end
         end
         default: state_nxt = ST_HUNT;
      endcase
   end

   // ----------------------------------------
   // input sampling and symbol timing
   // ----------------------------------------
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         in_s1_r <= 1'b0;
         in_s2_r <= 1'b0;
         in_d_r <= 1'b0;
         cnt_r <= '0;
         high_r <= '0;
         have_prev_r <= 1'b0;
      end else begin
         in_s1_r <= LINK.supply_symbol_input;
         in_s2_r <= in_s1_r;
         in_d_r <= in_s2_r;
         cnt_r <= rise ? '0 : (timeout ? cnt_r : cnt_r + 1'b1);
         if (fall) begin
            high_r <= cnt_r;
         end
         have_prev_r <= listening && !timeout && (rise || have_prev_r);
      end
   end

   // ----------------------------------------
   // command and data shifting
   // ----------------------------------------
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         state_r <= ST_HUNT;
         shift_r <= 8'h00;
         bitcnt_r <= 3'h0;
         bytes_r <= 4'h0;
         addr_r <= 7'h00;
      end else begin
         state_r <= state_nxt;
         if (is_bit) begin
            shift_r <= byte_in;
         end
         bitcnt_r <= (is_idle || is_bad || timeout || !listening) ? 3'h0
            : (is_bit ? bitcnt_r + 3'h1 : bitcnt_r);
         if (cmd_done) begin
            addr_r <= byte_in[6:0];
            bytes_r <= 4'h0;
         end else if (byte_done && state_r == ST_WDATA && bytes_r < pwc_pkg::MAX_BYTES) begin
            addr_r <= addr_r + 7'h01;
            bytes_r <= bytes_r + 4'h1;
         end
      end
   end

   // ----------------------------------------
   // register file
   // ----------------------------------------
   generate
      for (genvar g = 0; g < 128; g++) begin : g_mem
         always_ff @(posedge CLK or negedge RESETN) begin
            if (!RESETN) begin
               mem_r[g] <= pwc_pkg::reg_default(7'(g));
            end else if (mem_we && addr_r == 7'(g)) begin
               mem_r[g] <= byte_in;
            end
         end
      end
   endgenerate

   // ----------------------------------------
   // burn status and lock
   // ----------------------------------------
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         status_r <= pwc_pkg::STATUS_BASE;
         nv_done_r <= 1'b0;
         ro_r <= 1'b0;
         off_r <= 1'b0;
         burn_r <= 1'b0;
         burn_code_r <= 8'h00;
      end else begin
         nv_done_r <= 1'b1;
         if (!nv_done_r) begin
            status_r <= pwc_pkg::STATUS_BASE | (NV_STATUS & pwc_pkg::NV_MASK);
            ro_r <= NV_STATUS[pwc_pkg::ST_RO_POS];
            off_r <= NV_STATUS[pwc_pkg::ST_OFF_POS];
         end else if (burn_ok) begin
            status_r <= status_r | burn_mask;
         end
         burn_r <= burn_ok;
         if (burn_ok) begin
            burn_code_r <= byte_in;
         end
      end
   end

   // ----------------------------------------
   // response transmitter
   // ----------------------------------------
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         tx_cnt_r <= '0;
         tx_idx_r <= 7'h00;
         sink_r <= 1'b0;
         tx_act_r <= 1'b0;
         cfg_r <= 8'h00;
      end else begin
         if (state_r == ST_TURN) begin
            tx_cnt_r <= turn_end ? '0 : tx_cnt_r + 1'b1;
         end else if (state_r == ST_TX) begin
            tx_cnt_r <= tx_sym_end ? '0 : tx_cnt_r + 1'b1;
         end else begin
            tx_cnt_r <= '0;
         end
         tx_idx_r <= (state_r != ST_TX) ? 7'h00 : (tx_sym_end ? tx_idx_r + 7'h01 : tx_idx_r);
         sink_r <= (state_r == ST_TX) && (tx_cnt_r < tx_high);
         tx_act_r <= (state_nxt == ST_TURN) || (state_nxt == ST_TX);
         cfg_r <= cfg_byte;
      end
   end

   assign LINK.indicator_sink = sink_r;
   assign BURN_STROBE = burn_r;
   assign BURN_CODE = burn_code_r;
   assign CFG_DATA = cfg_r;
   assign TX_ACTIVE = tx_act_r;
endmodule : pwc_device

// ---- pwc_host.sv ----
// master end of the pulse coded configuration port with a register command port
`timescale 1ns/1ps
module pwc_host #(
   parameter int HOST_BIT_CYC = pwc_pkg::HOST_BIT_CYC,
   parameter int REPLY_WAIT_CYC = pwc_pkg::REPLY_WAIT_CYC
) (
   // clock and reset
   input wire logic CLK,
   input wire logic RESETN,
   // link to the device
   pulse_coded_port.host LINK,
   // software register port
   input wire logic [3:0] ADDR,
   input wire logic [7:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   output logic [7:0] RDATA
);
   localparam int W = pwc_pkg::CNT_W;

   typedef enum logic [2:0] {
      H_IDLE = 3'h1,
      H_SEND = 3'h2,
      H_LISTEN = 3'h4
   } host_state_type;

   host_state_type state_r;
   logic [6:0] target_r, s_idx_r, rx_bits_r;
   logic [3:0] count_r;
   logic dir_r, done_r, tout_r, bad_r, sym_r, got_idle_r, have_prev_r;
   logic k_s1_r, k_s2_r, k_d_r;
   logic [W-1:0] s_cnt_r, cnt_r, high_r, w_cnt_r;
   logic [7:0] shift_r, rdata_r;
   logic [7:0] buf_r [0:7];

   // ----------------------------------------
   // software decode
   // ----------------------------------------
   wire go = WR && (ADDR == pwc_pkg::HREG_CTRL) && WDATA[0] && (state_r == H_IDLE);
   wire stat_clr = WR && (ADDR == pwc_pkg::HREG_STAT);
   wire [7:0] stat = {4'h0, bad_r, tout_r, done_r, state_r != H_IDLE};
   wire [7:0] rd_val = ADDR[3] ? buf_r[ADDR[2:0]]
      : (ADDR == pwc_pkg::HREG_CTRL) ? {6'h00, dir_r, 1'b0}
      : (ADDR == pwc_pkg::HREG_TARGET) ? {1'b0, target_r}
      : (ADDR == pwc_pkg::HREG_COUNT) ? {4'h0, count_r}
      : (ADDR == pwc_pkg::HREG_STAT) ? stat : 8'h00;

   // ----------------------------------------
   // frame symbol generator
   // ----------------------------------------
   wire [7:0] head = {dir_r, target_r};
   wire [6:0] s_total = dir_r ? pwc_pkg::TX_SYMS_ONE : 7'(pwc_pkg::TX_SYMS_ONE + {count_r, 3'h0});
   wire [6:0] k = s_idx_r - 7'h09;
   wire [7:0] wbyte = buf_r[k[5:3]];
   wire s_idle = (s_idx_r == 7'h00) || (s_idx_r == s_total - 7'h01);
   wire s_bit = (s_idx_r <= 7'h08) ? head[3'(7'h08 - s_idx_r)] : wbyte[3'h7 - k[2:0]];
   wire [W-1:0] s_high = s_idle ? W'(HOST_BIT_CYC / 2)
      : s_bit ? W'((3 * HOST_BIT_CYC) / 4) : W'(HOST_BIT_CYC / 4);
   wire s_end = s_cnt_r == W'(HOST_BIT_CYC - 1);
   wire s_last = s_end && (s_idx_r == s_total - 7'h01);

   // ----------------------------------------
   // response decoder
   // ----------------------------------------
   wire rise = k_s2_r & ~k_d_r;
   wire fall = ~k_s2_r & k_d_r;
   wire [1:0] sym = pwc_pkg::classify(high_r, cnt_r,
      W'(HOST_BIT_CYC / pwc_pkg::HOST_MIN_DIV));
   wire sym_evt = rise && have_prev_r && (state_r == H_LISTEN);
   wire rx_bad = sym_evt && (sym == pwc_pkg::SYM_BAD || (got_idle_r && sym == pwc_pkg::SYM_IDLE));
   wire rx_bit = sym_evt && got_idle_r && (sym == pwc_pkg::SYM_ZERO || sym == pwc_pkg::SYM_ONE);
   wire [7:0] rx_byte = {shift_r[6:0], sym == pwc_pkg::SYM_ONE};
   wire rx_byte_done = rx_bit && (rx_bits_r[2:0] == 3'h7);
   wire [6:0] rx_need = (target_r == pwc_pkg::STATUS_ADDR) ? 7'h08 : 7'h40;
   wire rx_done = rx_bit && (rx_bits_r + 7'h01 == rx_need);
   wire w_end = w_cnt_r == W'(REPLY_WAIT_CYC - 1);
   wire end_txn = (state_r == H_SEND && s_last && !dir_r)
      || (state_r == H_LISTEN && (rx_done || rx_bad || w_end));

   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         state_r <= H_IDLE;
         s_cnt_r <= '0;
         s_idx_r <= 7'h00;
         sym_r <= 1'b0;
         w_cnt_r <= '0;
      end else begin
         case (state_r)
            H_IDLE: state_r <= go ? H_SEND : H_IDLE;
            H_SEND: state_r <= !s_last ? H_SEND : (dir_r ? H_LISTEN : H_IDLE);
            H_LISTEN: state_r <= end_txn ? H_IDLE : H_LISTEN;
            default: state_r <= H_IDLE;
         endcase
         s_cnt_r <= (state_r != H_SEND || s_end) ? '0 : s_cnt_r + 1'b1;
         s_idx_r <= (state_r != H_SEND) ? 7'h00 : (s_end ? s_idx_r + 7'h01 : s_idx_r);
         sym_r <= (state_r == H_SEND) && (s_cnt_r < s_high);
         w_cnt_r <= (state_r == H_LISTEN) ? w_cnt_r + 1'b1 : '0;
      end
   end

   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         k_s1_r <= 1'b0;
         k_s2_r <= 1'b0;
         k_d_r <= 1'b0;
         cnt_r <= '0;
         high_r <= '0;
         have_prev_r <= 1'b0;
         got_idle_r <= 1'b0;
         rx_bits_r <= 7'h00;
         shift_r <= 8'h00;
      end else begin
         k_s1_r <= LINK.indicator_sink;
         k_s2_r <= k_s1_r;
         k_d_r <= k_s2_r;
         cnt_r <= rise ? '0 : ((&cnt_r) ? cnt_r : cnt_r + 1'b1);
         if (fall) begin
            high_r <= cnt_r;
         end
         have_prev_r <= (state_r == H_LISTEN) && (rise || have_prev_r);
         got_idle_r <= (state_r == H_LISTEN) && (got_idle_r || (sym_evt && sym == pwc_pkg::SYM_IDLE));
         rx_bits_r <= (state_r != H_LISTEN) ? 7'h00 : (rx_bit ? rx_bits_r + 7'h01 : rx_bits_r);
         if (rx_bit) begin
            shift_r <= rx_byte;
         end
      end
   end

   // ----------------------------------------
   // software registers
   // ----------------------------------------
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         target_r <= 7'h00;
         count_r <= 4'h1;
         dir_r <= 1'b0;
         done_r <= 1'b0;
         tout_r <= 1'b0;
         bad_r <= 1'b0;
         rdata_r <= 8'h00;
      end else begin
         if (WR && ADDR == pwc_pkg::HREG_TARGET && state_r == H_IDLE) begin
            target_r <= WDATA[6:0];
         end
         if (WR && ADDR == pwc_pkg::HREG_COUNT && state_r == H_IDLE) begin
            count_r <= (WDATA[3:0] > pwc_pkg::MAX_BYTES) ? pwc_pkg::MAX_BYTES : WDATA[3:0];
         end
         if (go) begin
            dir_r <= WDATA[1];
         end
         done_r <= end_txn || (done_r && !(stat_clr && WDATA[1]));
         tout_r <= (state_r == H_LISTEN && w_end) || (tout_r && !(stat_clr && WDATA[2]));
         bad_r <= rx_bad || (bad_r && !(stat_clr && WDATA[3]));
         rdata_r <= RD ? rd_val : 8'h00;
      end
   end

   generate
      for (genvar g = 0; g < 8; g++) begin : g_buf
         always_ff @(posedge CLK or negedge RESETN) begin
            if (!RESETN) begin
               buf_r[g] <= 8'h00;
            end else if (rx_byte_done && rx_bits_r[5:3] == 3'(g)) begin
               buf_r[g] <= rx_byte;
            end else if (WR && ADDR == (pwc_pkg::HREG_BUF | 4'(g)) && state_r == H_IDLE) begin
               buf_r[g] <= WDATA;
            end
         end
      end
   endgenerate

   assign LINK.supply_symbol_input = sym_r;
   assign RDATA = rdata_r;
endmodule : pwc_host

// ---- pwc_link_checker.sv ----
// assertions on the link wires between host and device ends
`timescale 1ns/1ps
module pwc_link_checker #(
   parameter int TXB = 200,
   parameter int HB = 200
) (
   // clock and reset
   input wire logic CLK,
   input wire logic RESETN,
   // link wires
   input wire logic supply_symbol_input,
   input wire logic indicator_sink
);
   logic [19:0] sh_r, sl_r, sp_r, hh_r, hl_r, hp_r;
   logic [6:0] np_r;
   logic sk_r, hk_r, fl_r;
   wire s_up = indicator_sink && !sk_r;
   default clocking @(posedge CLK); endclocking
   default disable iff (!RESETN);
   // high, low and previous high run lengths of both wires
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         {sh_r, sl_r, sp_r, hh_r, hl_r, hp_r, np_r, sk_r, hk_r, fl_r} <= '0;
      end else begin
         sk_r <= indicator_sink;
         hk_r <= supply_symbol_input;
         sh_r <= indicator_sink ? sh_r + 20'h1 : 20'h0;
         sl_r <= indicator_sink ? 20'h0 : sl_r + {19'h0, ~&sl_r};
         hh_r <= supply_symbol_input ? hh_r + 20'h1 : 20'h0;
         hl_r <= supply_symbol_input ? 20'h0 : hl_r + {19'h0, ~&hl_r};
         sp_r <= (sk_r && !indicator_sink) ? sh_r : sp_r;
         hp_r <= (hk_r && !supply_symbol_input) ? hh_r : hp_r;
         np_r <= s_up ? np_r + 7'h1 : (sl_r > 2 * TXB ? 7'h0 : np_r);
         fl_r <= s_up ? (sl_r > 2 * TXB) : fl_r;
      end
   end
   sink_len_a: assert property ($fell(indicator_sink) |->
      sh_r == TXB / 4 || sh_r == TXB / 2 || sh_r == TXB * 3 / 4) else $error("sink width");
   sink_rate_a: assert property ($rose(indicator_sink) && sp_r != 0 && sl_r < TXB
      |-> sp_r + sl_r == TXB) else $error("sink period");
   sink_open_a: assert property ($fell(indicator_sink) && fl_r |-> sh_r == TXB / 2)
      else $error("reply does not open with idle");
   reply_len_a: assert property (sl_r == 2 * TXB && np_r != 0 |-> np_r == 10 || np_r == 66)
      else $error("reply symbol count");
   turn_gap_a: assert property ($rose(indicator_sink) |->
      hl_r > TXB + pwc_pkg::TURN_GAP_CYC - HB / 2)
      else $error("reply too early");
   line_quiet_a: assert property (indicator_sink |-> !supply_symbol_input)
      else $error("both ends active");
   host_len_a: assert property ($fell(supply_symbol_input) |->
      hh_r == HB / 4 || hh_r == HB / 2 || hh_r == HB * 3 / 4) else $error("host width");
   host_rate_a: assert property ($rose(supply_symbol_input) && hp_r != 0 && hl_r < HB
      |-> hp_r + hl_r == HB) else $error("host period");
endmodule : pwc_link_checker

// ---- pulse_width_config_port_test.sv ----
// bench joining host and device ends through the link
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin bad_count++; \
   $display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); end end
module pulse_width_config_port_test;
   logic CLK = 1'b0, RESETN = 1'b0, WR = 1'b0, RD = 1'b0, BURN_STROBE, TX_ACTIVE;
   logic [3:0] ADDR = 4'h0;
   logic [7:0] WDATA = 8'h00, NV_STATUS = 8'h00, RDATA, CFG_DATA, BURN_CODE, s, st;
   logic [6:0] CFG_ADDR = 7'h00;
   int bad_count = 0, tests_run = 0, cyc = 0, burns = 0, act = 0;
   // bit time of both ends, short to keep the run brief
   localparam int P = 200;
   // target, data, readback address, expected readback
   logic [7:0] rows [6][4] = '{'{8'h66, 8'h5a, 8'h66, 8'h5a}, '{8'h5e, 8'h33, 8'h5e, 8'h00},
      '{8'h7f, 8'h08, 8'h7e, 8'h21}, '{8'h7f, 8'h20, 8'h7e, 8'h23},
      '{8'h7f, 8'h10, 8'h7e, 8'h23}, '{8'h7f, 8'h40, 8'h7e, 8'h27}};
   always #10 CLK = ~CLK;
   pulse_coded_port i_pulse_coded_port();
   pwc_device #(.TX_BIT_CYC(P), .RX_TIMEOUT_CYC(4000)) i_pwc_device(.CLK(CLK),
      .RESETN(RESETN), .LINK(i_pulse_coded_port), .NV_STATUS(NV_STATUS),
      .BURN_STROBE(BURN_STROBE), .BURN_CODE(BURN_CODE), .CFG_ADDR(CFG_ADDR),
      .CFG_DATA(CFG_DATA), .TX_ACTIVE(TX_ACTIVE));
   pwc_host #(.HOST_BIT_CYC(P), .REPLY_WAIT_CYC(15000)) i_pwc_host(.CLK(CLK),
      .RESETN(RESETN), .LINK(i_pulse_coded_port), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
      .RD(RD), .RDATA(RDATA));
   pwc_link_checker i_pwc_link_checker(.CLK(CLK), .RESETN(RESETN),
      .supply_symbol_input(i_pulse_coded_port.supply_symbol_input),
      .indicator_sink(i_pulse_coded_port.indicator_sink));
   task results;
      $display("tests %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : results
   task wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge CLK);
      ADDR <= a;
      WDATA <= d;
      WR <= 1'b1;
      @(posedge CLK);
      WR <= 1'b0;
   endtask : wr
   task rd(input logic [3:0] a);
      @(posedge CLK);
      ADDR <= a;
      RD <= 1'b1;
      @(posedge CLK);
      RD <= 1'b0;
      #1 s = RDATA;
   endtask : rd
   // one transfer: one byte written, or one status byte or eight bytes read; ends with the line quiet again
   task frame(input logic [7:0] t, input logic [7:0] d, input logic [7:0] c);
      wr(pwc_pkg::HREG_TARGET, t);
      wr(pwc_pkg::HREG_COUNT, 8'h01);
      wr(pwc_pkg::HREG_BUF, d);
      wr(pwc_pkg::HREG_CTRL, c);
      s = 8'h00;
      repeat (10000) if (s[2:1] === 2'b00) rd(pwc_pkg::HREG_STAT);
      `CHK(s[2] | s[1], 1'b1)
      st = s;
      wr(pwc_pkg::HREG_STAT, 8'h0e);
      repeat (1000) @(posedge CLK);
      rd(pwc_pkg::HREG_BUF);
   endtask : frame
   task rst(input logic [7:0] nv);
      RESETN <= 1'b0;
      NV_STATUS <= nv;
      repeat (16) @(posedge CLK);
      RESETN <= 1'b1;
   endtask : rst
   task cfg(input logic [6:0] a, input logic [7:0] e);
      CFG_ADDR <= a;
      repeat (3) @(posedge CLK);
      `CHK(CFG_DATA, e)
   endtask : cfg
   always @(posedge CLK) begin
      cyc++;
      if (BURN_STROBE === 1'b1) burns++;
      if (TX_ACTIVE === 1'b1) act++;
      if (cyc == 100000) begin
         bad_count++;
         results;
      end
   end
   initial begin
      rst(8'h00);
      for (int i = 0; i < 6; i++) begin
         frame(rows[i][0], rows[i][1], 8'h01);
         cfg(rows[i][2][6:0], rows[i][3]);
         $display("row %0d done", i);
      end
      `CHK(BURN_CODE, pwc_pkg::BURN_RO)
      frame(8'h7f, 8'h80, 8'h01);
      frame(8'h7e, 8'h00, 8'h03);
      `CHK(s, 8'h2f)
      `CHK(act, pwc_pkg::TURN_GAP_CYC + 11 * P)
      $display("disable burn done");
      rst(8'h04);
      frame(8'h6e, 8'h77, 8'h01);
      cfg(7'h6e, pwc_pkg::DEF_OSC0);
      frame(8'h7e, 8'h00, 8'h03);
      `CHK(s, 8'h24)
      frame(8'h6e, 8'h00, 8'h03);
      `CHK(s, pwc_pkg::DEF_OSC0)
      `CHK(act, 3 * (pwc_pkg::TURN_GAP_CYC + P) + 86 * P)
      `CHK(burns, 5)
      $display("read only done");
      rst(8'h08);
      frame(8'h7e, 8'h00, 8'h03);
      `CHK(st[2], 1'b1)
      `CHK(act, 3 * (pwc_pkg::TURN_GAP_CYC + P) + 86 * P)
      $display("disabled done");
      results;
   end
endmodule : pulse_width_config_port_test
